/* design/ticfg_pkg.sv */
// Package of constants for the timer input configuration block
// Function
// - A write strobe with the port selected captures the data byte into the config latch.
// - One latch bit routes either the processor clock or the diagnostic signal to counter 2 clock.
// - One latch bit makes counter 2 gate either always enabled or the diagnostic signal.
// - With the diagnostic gate and the processor clock chosen, counter 2 counts processor clocks only while it is active.
// - One latch bit routes either the processor clock or counter 2 output to counter 1 clock.
// - The two low latch bits invert the counter 1 and counter 2 outputs toward the interrupts.
// - The latch may be rewritten at any time and new selections take effect at once.
// - Counter 0 always runs from the 2 MHz clock with its gate always enabled.
// - A rising edge of counter 0 output sets the tick interrupt flip-flop.
// - A read of the configuration port clears the tick interrupt flip-flop.
// - Counter 0 counts without stop, ticks at maximum count, wraps to zero and goes on.
// - Only the low data byte is used and one device is accessed per cycle.
package ticfg_pkg;
    localparam logic [15:0] TICFG_CFG_ADDR = 16'h3200; // Port address, decoded outside
    localparam int TICFG_DATA_W = 8;
    localparam logic [7:0] TICFG_CFG_RESET = 8'h00;
    localparam int TICFG_BIT_INV_C1 = 0;
    localparam int TICFG_BIT_INV_C2 = 1;
    localparam int TICFG_BIT_C2_CLK = 2;
    localparam int TICFG_BIT_C2_GATE = 3;
    localparam int TICFG_BIT_C1_CLK = 4;
    localparam int TICFG_SYNC_STAGES = 3;
    localparam int TICFG_C0_WIDTH = 16; // Counter 0 width, plain default
    // Positions within the synchronised pin vector
    localparam int TICFG_PIN_DATA = 0;
    localparam int TICFG_PIN_SEL = 8;
    localparam int TICFG_PIN_WR = 9;
    localparam int TICFG_PIN_RD = 10;
    localparam int TICFG_PIN_DIAG = 11;
    localparam int TICFG_PIN_PCLK = 12;
    localparam int TICFG_PIN_CLK2M = 13;
    localparam int TICFG_PIN_C1OUT = 14;
    localparam int TICFG_PIN_C2OUT = 15;
    localparam int TICFG_PIN_W = 16;
    localparam logic [TICFG_PIN_W-1:0] TICFG_PIN_RESET = 16'h0700;
endpackage : ticfg_pkg

/* design/ticfg_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ticfg_pin_sync
    import ticfg_pkg::*;
#(
    parameter int WIDTH = TICFG_PIN_W,
    parameter logic [TICFG_PIN_W-1:0] INIT = TICFG_PIN_RESET
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins in, filtered levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] mid_ff;
    logic [WIDTH-1:0] last_ff;
    logic [WIDTH-1:0] level_ff;
    logic [WIDTH-1:0] nxt_level;

    // Accept a change once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            nxt_level[i] = (mid_ff[i] == last_ff[i]) ? last_ff[i] : level_ff[i];
        end
    end

    // Synchroniser chain
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= INIT[WIDTH-1:0];
            mid_ff <= INIT[WIDTH-1:0];
            last_ff <= INIT[WIDTH-1:0];
            level_ff <= INIT[WIDTH-1:0];
        end
        else
        begin
            meta_ff <= pin_in;
            mid_ff <= meta_ff;
            last_ff <= mid_ff;
            level_ff <= nxt_level;
        end
    end

    assign level_out = level_ff;
endmodule : ticfg_pin_sync

/* design/ticfg_timer_config.sv */
// Timer input configuration latch, source muxes and tick interrupt
`timescale 1ns/1ps
module ticfg_timer_config
    import ticfg_pkg::*;
#(
    parameter int C0_WIDTH = TICFG_C0_WIDTH
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Processor I/O bus, low byte only
    input wire logic timer_cfg_select_n,
    input wire logic io_write_strobe_n,
    input wire logic io_read_strobe_n,
    input wire logic [7:0] io_data_in,
    output logic [7:0] io_data_out,
    output logic io_data_oe,
    // Clock sources and diagnostic signal
    input wire logic pclk_in,
    input wire logic clk2m_in,
    input wire logic diag_event_signal,
    // Counter connections
    input wire logic counter1_out,
    input wire logic counter2_out,
    output logic counter2_clk,
    output logic counter2_gate_input,
    output logic counter1_clk,
    // Interrupt requests to the processor
    output logic counter1_irq,
    output logic counter2_irq,
    output logic timer_tick_irq,
    // Latch contents for observation
    output logic [7:0] timer_input_config
);
    logic [TICFG_PIN_W-1:0] pins;
    logic [TICFG_PIN_W-1:0] lvl;
    logic [7:0] data_s;
    logic sel_s;
    logic wr_s;
    logic rd_s;
    logic diag_s;
    logic pclk_s;
    logic clk2m_s;
    logic wr_prev_ff;
    logic rd_prev_ff;
    logic clk2m_prev_ff;
    logic wr_ev;
    logic rd_ev;
    logic c0_step;
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic irq_ff;
    logic nxt_irq;
    logic [C0_WIDTH-1:0] c0_cnt_ff;
    logic [C0_WIDTH-1:0] nxt_c0_cnt;
    logic c0_out_ff;
    logic nxt_c0_out;
    logic c0_rise;
    logic [7:0] dout_ff;
    logic [7:0] nxt_dout;
    logic oe_ff;
    logic nxt_oe;
    logic c2clk_ff;
    logic nxt_c2clk;
    logic c2gate_ff;
    logic nxt_c2gate;
    logic c1clk_ff;
    logic nxt_c1clk;
    logic c1irq_ff;
    logic nxt_c1irq;
    logic c2irq_ff;
    logic nxt_c2irq;

    // Every pin input crosses in through the filter
    assign pins = {counter2_out, counter1_out, clk2m_in, pclk_in, diag_event_signal,
                   io_read_strobe_n, io_write_strobe_n, timer_cfg_select_n, io_data_in};

    ticfg_pin_sync #(.WIDTH(TICFG_PIN_W), .INIT(TICFG_PIN_RESET)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pin_in(pins),
        .level_out(lvl)
    );

    // Field extraction from filtered pins
    assign data_s = lvl[TICFG_PIN_DATA +: TICFG_DATA_W];
    assign sel_s = ~lvl[TICFG_PIN_SEL];
    assign wr_s = ~lvl[TICFG_PIN_WR];
    assign rd_s = ~lvl[TICFG_PIN_RD];
    assign diag_s = lvl[TICFG_PIN_DIAG];
    assign pclk_s = lvl[TICFG_PIN_PCLK];
    assign clk2m_s = lvl[TICFG_PIN_CLK2M];

    // Bus events: latch on strobe release, clear on read start
    assign wr_ev = wr_prev_ff && !wr_s && sel_s;
    assign rd_ev = !rd_prev_ff && rd_s && sel_s;
    assign c0_step = clk2m_s && !clk2m_prev_ff;
    assign c0_rise = nxt_c0_out && !c0_out_ff;

    // Configuration latch, writable at any time
    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (wr_ev)
        begin
            nxt_cfg = data_s;
        end
    end

    // Counter 0: free running, ticks at maximum, wraps
    always_comb
    begin
        nxt_c0_cnt = c0_cnt_ff;
        nxt_c0_out = c0_out_ff;
        if (c0_step)
        begin
            nxt_c0_cnt = c0_cnt_ff + 1'b1;
            nxt_c0_out = (c0_cnt_ff == {C0_WIDTH{1'b1}});
        end
    end

    // Tick interrupt: a new tick wins over a clearing read
    always_comb
    begin
        nxt_irq = irq_ff;
        if (rd_ev)
        begin
            nxt_irq = 1'b0;
        end
        if (c0_rise)
        begin
            nxt_irq = 1'b1;
        end
    end

    // Source muxes, gate and output inversion
    always_comb
    begin
        nxt_c2clk = cfg_ff[TICFG_BIT_C2_CLK] ? diag_s : pclk_s;
        nxt_c2gate = cfg_ff[TICFG_BIT_C2_GATE] ? diag_s : 1'b1;
        nxt_c1clk = cfg_ff[TICFG_BIT_C1_CLK] ? lvl[TICFG_PIN_C2OUT] : pclk_s;
        nxt_c1irq = lvl[TICFG_PIN_C1OUT] ^ cfg_ff[TICFG_BIT_INV_C1];
        nxt_c2irq = lvl[TICFG_PIN_C2OUT] ^ cfg_ff[TICFG_BIT_INV_C2];
        nxt_oe = sel_s && rd_s;
        nxt_dout = cfg_ff;
    end

    // State registers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_ff <= TICFG_CFG_RESET;
            irq_ff <= 1'b0;
            c0_cnt_ff <= '0;
            c0_out_ff <= 1'b0;
            wr_prev_ff <= 1'b0;
            rd_prev_ff <= 1'b0;
            clk2m_prev_ff <= 1'b0;
            dout_ff <= 8'h00;
            oe_ff <= 1'b0;
            c2clk_ff <= 1'b0;
            c2gate_ff <= 1'b1;
            c1clk_ff <= 1'b0;
            c1irq_ff <= 1'b0;
            c2irq_ff <= 1'b0;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            irq_ff <= nxt_irq;
            c0_cnt_ff <= nxt_c0_cnt;
            c0_out_ff <= nxt_c0_out;
            wr_prev_ff <= wr_s;
            rd_prev_ff <= rd_s;
            clk2m_prev_ff <= clk2m_s;
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
            c2clk_ff <= nxt_c2clk;
            c2gate_ff <= nxt_c2gate;
            c1clk_ff <= nxt_c1clk;
            c1irq_ff <= nxt_c1irq;
            c2irq_ff <= nxt_c2irq;
        end
    end

    // Outputs, all from flip-flops
    assign io_data_out = dout_ff;
    assign io_data_oe = oe_ff;
    assign counter2_clk = c2clk_ff;
    assign counter2_gate_input = c2gate_ff;
    assign counter1_clk = c1clk_ff;
    assign counter1_irq = c1irq_ff;
    assign counter2_irq = c2irq_ff;
    assign timer_tick_irq = irq_ff;
    assign timer_input_config = cfg_ff;

    // Checks on latch, muxes and interrupt
    chk_cfg_capture: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ev |=> timer_input_config == $past(data_s))
        else $error("config latch missed a write");
    chk_cfg_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !wr_ev |=> $stable(timer_input_config))
        else $error("config latch changed without a write");
    chk_c2_clock_mux: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 counter2_clk == ($past(cfg_ff[TICFG_BIT_C2_CLK]) ? $past(diag_s) : $past(pclk_s)))
        else $error("counter 2 clock source wrong");
    chk_c2_gate_open: assert property (@(posedge clock) disable iff (!rst_n)
        !cfg_ff[TICFG_BIT_C2_GATE] |=> counter2_gate_input)
        else $error("counter 2 gate not enabled");
    chk_c2_gate_diag: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_ff[TICFG_BIT_C2_GATE] |=> counter2_gate_input == $past(diag_s))
        else $error("counter 2 gate does not follow diagnostic");
    chk_c1_clock_mux: assert property (@(posedge clock) disable iff (!rst_n)
        cfg_ff[TICFG_BIT_C1_CLK] |=> counter1_clk == $past(lvl[TICFG_PIN_C2OUT]))
        else $error("counter 1 not cascaded");
    chk_out_invert: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 (counter1_irq == ($past(lvl[TICFG_PIN_C1OUT]) ^ $past(cfg_ff[TICFG_BIT_INV_C1])))
        && (counter2_irq == ($past(lvl[TICFG_PIN_C2OUT]) ^ $past(cfg_ff[TICFG_BIT_INV_C2]))))
        else $error("counter output inversion wrong");
    chk_tick_set: assert property (@(posedge clock) disable iff (!rst_n)
        c0_rise |=> timer_tick_irq)
        else $error("tick did not raise interrupt");
    chk_tick_clear: assert property (@(posedge clock) disable iff (!rst_n)
        rd_ev && !c0_rise |=> !timer_tick_irq)
        else $error("read did not clear interrupt");
    chk_c0_wrap: assert property (@(posedge clock) disable iff (!rst_n)
        c0_step && (c0_cnt_ff == {C0_WIDTH{1'b1}}) |=> (c0_cnt_ff == '0) && c0_out_ff)
        else $error("counter 0 did not wrap with tick");
endmodule : ticfg_timer_config

/* bench/ticfg_proc_model.sv */
// Executive processor model driving the configuration port
`timescale 1ns/1ps
module ticfg_proc_model
(
    // Clock
    input wire logic clock,
    // Byte bus towards the block
    output logic timer_cfg_select_n,
    output logic io_write_strobe_n,
    output logic io_read_strobe_n,
    output logic [7:0] io_data_in,
    input wire logic [7:0] io_data_out,
    input wire logic io_data_oe
);
    // Bus idle at time zero
    initial
    begin
        timer_cfg_select_n = 1'b1;
        io_write_strobe_n = 1'b1;
        io_read_strobe_n = 1'b1;
        io_data_in = 8'h00;
    end
    // Wait a number of falling edges
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle
    // Port write, one low byte per access
    task automatic io_write(input logic [7:0] value);
        timer_cfg_select_n = 1'b0;
        io_data_in = value;
        idle(1);
        io_write_strobe_n = 1'b0;
        idle(4);
        io_write_strobe_n = 1'b1;
        idle(6);
        timer_cfg_select_n = 1'b1;
        io_data_in = ~value; // Released bus shows no stale byte
        idle(4);
    endtask : io_write
    // Port read, also the tick acknowledge
    task automatic io_read(output logic [7:0] value, output logic ok);
        ok = 1'b0;
        value = 8'h00;
        timer_cfg_select_n = 1'b0;
        io_read_strobe_n = 1'b0;
        for (int n = 0; n < 20 && !ok; n++)
        begin
            idle(1);
            ok = (io_data_oe === 1'b1);
        end
        value = io_data_out;
        io_read_strobe_n = 1'b1;
        timer_cfg_select_n = 1'b1;
        idle(8);
    endtask : io_read
endmodule : ticfg_proc_model

/* bench/ticfg_timer_config_tb.sv */
// Self-checking bench for the timer input configuration block
`timescale 1ns/1ps
module ticfg_timer_config_tb;
    import ticfg_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sel_n, wr_n, rd_n, oe, c2_clk, c2_gate, c1_clk, c1_irq, c2_irq, tick_irq;
    logic [7:0] din, dout, cfg, rd_val;
    logic pclk_in;
    logic clk2m_in;
    logic diag;
    logic c1_out;
    logic c2_out;
    logic rd_ok;
    int fail_count = 0;
    int compares = 0;
    // 25 MHz clock
    always #20 clock = ~clock;
    ticfg_timer_config #(.C0_WIDTH(3)) u_dut (.clock(clock), .rst_n(rst_n),
        .timer_cfg_select_n(sel_n), .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n),
        .io_data_in(din), .io_data_out(dout), .io_data_oe(oe), .pclk_in(pclk_in),
        .clk2m_in(clk2m_in), .diag_event_signal(diag), .counter1_out(c1_out),
        .counter2_out(c2_out), .counter2_clk(c2_clk), .counter2_gate_input(c2_gate),
        .counter1_clk(c1_clk), .counter1_irq(c1_irq), .counter2_irq(c2_irq),
        .timer_tick_irq(tick_irq), .timer_input_config(cfg));
    ticfg_proc_model u_proc (.clock(clock), .timer_cfg_select_n(sel_n),
        .io_write_strobe_n(wr_n), .io_read_strobe_n(rd_n), .io_data_in(din),
        .io_data_out(dout), .io_data_oe(oe));
    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Verdict and end of run
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // Write then read back two patterns
    task automatic test_write_read;
        for (int i = 0; i < 2; i++)
        begin
            u_proc.io_write(i ? 8'h5A : 8'hA5);
            check(cfg, i ? 8'h5A : 8'hA5);
            u_proc.io_read(rd_val, rd_ok);
            check({7'h00, rd_ok}, 8'h01);
            check(rd_val, i ? 8'h5A : 8'hA5);
        end
    endtask : test_write_read
    // All input levels under one selection
    task automatic test_mux(input logic [7:0] sel);
        logic [7:0] exp;
        u_proc.io_write(sel);
        for (int k = 0; k < 16; k++)
        begin
            pclk_in = k[3];
            diag = k[2];
            c1_out = k[1];
            c2_out = k[0];
            u_proc.idle(8);
            exp = {3'h0, sel[TICFG_BIT_C2_CLK] ? diag : pclk_in,
                   sel[TICFG_BIT_C2_GATE] ? diag : 1'b1,
                   sel[TICFG_BIT_C1_CLK] ? c2_out : pclk_in,
                   c1_out ^ sel[TICFG_BIT_INV_C1], c2_out ^ sel[TICFG_BIT_INV_C2]};
            check({3'h0, c2_clk, c2_gate, c1_clk, c1_irq, c2_irq}, exp);
        end
    endtask : test_mux
    // Rising edges on the 2 MHz input
    task automatic pulses(input int n);
        repeat (n)
        begin
            clk2m_in = 1'b1;
            u_proc.idle(6);
            clk2m_in = 1'b0;
            u_proc.idle(6);
        end
    endtask : pulses
    // Tick every eight edges, cleared by a port read
    task automatic test_tick;
        repeat (2)
        begin
            pulses(7);
            check({7'h00, tick_irq}, 8'h00);
            pulses(1);
            u_proc.idle(4);
            check({7'h00, tick_irq}, 8'h01);
            u_proc.io_read(rd_val, rd_ok);
            check({7'h00, rd_ok}, 8'h01);
            check({7'h00, tick_irq}, 8'h00);
        end
    endtask : test_tick
    // Main sequence
    initial
    begin
        pclk_in = 1'b0;
        clk2m_in = 1'b0;
        diag = 1'b0;
        c1_out = 1'b0;
        c2_out = 1'b0;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        u_proc.idle(8);
        check(cfg, TICFG_CFG_RESET);
        check({5'h00, c2_gate, c1_irq, tick_irq}, 8'h04);
        test_write_read();
        test_mux(8'h00);
        test_mux(8'h1F);
        test_mux(8'h0A);
        test_mux(8'h15);
        test_mux(8'h03);
        test_tick();
        complete_run();
    end
    // Watchdog
    initial
    begin
        #2000000;
        fail_count++;
        complete_run();
    end
endmodule : ticfg_timer_config_tb
